// >>> pkg/cprs_defs.svh
// Constants for the CPU processor register set
`ifndef CPRS_DEFS_SVH
`define CPRS_DEFS_SVH

// Status word flag positions
`define CPRS_PSW_IE 7
`define CPRS_PSW_Z 6
`define CPRS_PSW_BANK_SELECT_HIGH 5
`define CPRS_PSW_AC 4
`define CPRS_PSW_BANK_SELECT_LOW 3
`define CPRS_PSW_ISP 1
`define CPRS_PSW_CY 0
`define CPRS_PSW_RESET 8'h02

// Address map
`define CPRS_VEC_RESET_LO 16'h0000
`define CPRS_VEC_RESET_HI 16'h0001
`define CPRS_GPR_BASE 16'hfee0
`define CPRS_GPR_LAST 16'hfeff
`define CPRS_SFR_PAGE 8'hff
`define CPRS_SP_RESET 16'h0000

`endif

// >>> pkg/cprs_pkg.sv
// Types for the CPU processor register set
package cprs_pkg;

    // Status word operation selected by the sequencer
    typedef enum logic [3:0] {
        CPRS_PSW_NOP = 4'h0,
        CPRS_PSW_DI = 4'h1,
        CPRS_PSW_EI = 4'h2,
        CPRS_PSW_SEL = 4'h3,
        CPRS_PSW_POP = 4'h4,
        CPRS_PSW_WR = 4'h5,
        CPRS_PSW_ACK = 4'h6
    } cprs_psw_op_t;

    // Stack pointer operation
    typedef enum logic [2:0] {
        CPRS_SP_NOP = 3'h0,
        CPRS_SP_LOAD = 3'h1,
        CPRS_SP_PUSH = 3'h2,
        CPRS_SP_POP = 3'h3
    } cprs_sp_op_t;

    // Program counter operation
    typedef enum logic [1:0] {
        CPRS_PC_HOLD = 2'h0,
        CPRS_PC_STEP = 2'h1,
        CPRS_PC_BRANCH = 2'h2
    } cprs_pc_op_t;

    // Reset vector fetch states, one-hot
    typedef enum logic [3:0] {
        CPRS_ST_VLO = 4'b0001,
        CPRS_ST_VHI = 4'b0010,
        CPRS_ST_RUN = 4'b0100,
        CPRS_ST_IDLE = 4'b1000
    } cprs_state_t;

    // Result flags from the ALU
    typedef struct packed {
        logic zero_upd;
        logic zero;
        logic ac_upd;
        logic ac;
        logic cy_upd;
        logic cy;
    } cprs_flags_t;

    // Register file access (general registers and SFR page)
    typedef struct packed {
        logic rd;
        logic wr;
        logic wide;
        logic [15:0] addr;
        logic [15:0] wdata;
    } cprs_acc_t;

endpackage

// >>> design/cprs_gpr_bank.sv
// Four banks of eight byte-wide general registers with pair access
`timescale 1ns/1ns
`include "cprs_defs.svh"
module cprs_gpr_bank
    import cprs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Bank-relative access
    input wire logic [1:0] bank,
    input wire logic wr,
    input wire logic wide,
    input wire logic [2:0] idx,
    input wire logic [15:0] wdata,
    // Direct memory-mapped access
    input wire logic mem_wr,
    input wire logic mem_wide,
    input wire logic [4:0] mem_idx,
    input wire logic [15:0] mem_wdata,
    // Read data
    output logic [15:0] rdata,
    output logic [15:0] mem_rdata
);
    logic [7:0] regs_q [0:31];

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    // RL18 bank mapping, RL19 byte or pair write; a pair uses the even slot low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 32; i++) begin
                regs_q[i] <= 8'h00;
            end
        end else if (ce) begin
            if (wr) begin
                if (wide) begin
                    regs_q[{bank, idx[2:1], 1'b0}] <= wdata[7:0];
                    regs_q[{bank, idx[2:1], 1'b1}] <= wdata[15:8];
                end else begin
                    regs_q[{bank, idx}] <= wdata[7:0];
                end
            end else if (mem_wr) begin
                if (mem_wide) begin
                    regs_q[{mem_idx[4:1], 1'b0}] <= mem_wdata[7:0];
                    regs_q[{mem_idx[4:1], 1'b1}] <= mem_wdata[15:8];
                end else begin
                    regs_q[mem_idx] <= mem_wdata[7:0];
                end
            end
        end
    end

    // RL19 pair reads
    always_comb begin
        if (wide) begin
            rdata = {regs_q[{bank, idx[2:1], 1'b1}], regs_q[{bank, idx[2:1], 1'b0}]};
        end else begin
            rdata = {8'h00, regs_q[{bank, idx}]};
        end
        if (mem_wide) begin
            mem_rdata = {regs_q[{mem_idx[4:1], 1'b1}], regs_q[{mem_idx[4:1], 1'b0}]};
        end else begin
            mem_rdata = {8'h00, regs_q[mem_idx]};
        end
    end
endmodule

// >>> design/cprs_core.sv
// CPU processor register set: program counter, status word, stack pointer, register window
//
// Operation
// RL1 - Program counter advances by instruction length
// RL2 - Reset loads counter from vector word
// RL3 - Branch loads counter with target value
// RL4 - Status word pushed on acknowledge or push
// RL5 - Status word restored on return or pop
// RL6 - Status word resets to two
// RL7 - Enable clear refuses all maskable requests
// RL8 - Enable set: priority, mask, level decide
// RL9 - Disable and acknowledge clear, enable sets
// RL10 - Zero flag follows result being zero
// RL11 - Bank field chooses one of four banks
// RL12 - Auxiliary carry from bit three
// RL13 - Low priority blocked while priority flag clear
// RL14 - Carry for arithmetic, rotates, bit operations
// RL15 - Software keeps stack in fast RAM
// RL16 - Stack pointer predecrements, postincrements
// RL17 - Software loads stack pointer before use
// RL18 - Four banks mapped to fixed range
// RL19 - Byte or pair register access
// RL20 - Top page decoded with unit checks
// RL21 - Software uses even addresses for pairs
// RL22 - Vector low byte even, high odd
// RL23 - Status word flag positions fixed
`timescale 1ns/1ns
`include "cprs_defs.svh"
module cprs_core
    import cprs_pkg::*;
(
    // Clock, reset and enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Program memory byte port for the reset vector
    output logic [15:0] pmem_addr,
    output logic pmem_rd,
    input wire logic [7:0] pmem_rdata,
    // Program counter control
    input wire cprs_pc_op_t pc_op,
    input wire logic [1:0] instr_len_m1,
    input wire logic [15:0] branch_target,
    output logic [15:0] program_counter,
    output logic fetch_ready,
    // Status word control
    input wire cprs_psw_op_t psw_op,
    input wire logic [1:0] select_bank,
    input wire logic [7:0] psw_wdata,
    input wire cprs_flags_t alu_flags,
    output logic [7:0] program_status_word,
    // Stack
    input wire cprs_sp_op_t sp_op,
    input wire logic [1:0] sp_len,
    input wire logic [15:0] sp_wdata,
    output logic [15:0] stack_pointer,
    output logic [15:0] stack_addr,
    // Interrupt acknowledge decision
    input wire logic irq_pending,
    input wire logic irq_masked,
    input wire logic irq_low_prio,
    output logic irq_accept,
    // Bank-relative register access
    input wire logic gpr_wr,
    input wire logic gpr_wide,
    input wire logic [2:0] gpr_idx,
    input wire logic [15:0] gpr_wdata,
    output logic [15:0] gpr_rdata,
    // Data memory window access
    input wire cprs_acc_t mem_acc,
    input wire logic [2:0] sfr_unit,
    output logic [15:0] mem_rdata,
    output logic mem_hit_gpr,
    output logic mem_hit_sfr,
    output logic sfr_sel,
    output logic sfr_err
);
    logic [15:0] pc_q;
    logic [7:0] psw_q;
    logic [15:0] sp_q;
    logic [7:0] vlo_q;
    logic [15:0] mem_rdata_q;
    logic sfr_sel_q;
    logic sfr_err_q;
    cprs_state_t state_q;
    logic [15:0] gpr_mem_rdata;

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------
    // Address lies in the general register range
    function automatic logic is_gpr(input logic [15:0] a);
        is_gpr = (a >= `CPRS_GPR_BASE) && (a <= `CPRS_GPR_LAST);
    endfunction

    // Address lies in the SFR page
    function automatic logic is_sfr(input logic [15:0] a);
        is_sfr = (a[15:8] == `CPRS_SFR_PAGE);
    endfunction

    // ----------------------------------------
    // Reset vector sequencer
    // ----------------------------------------
    // RL2 fetch vector after reset release; RL22 low byte first
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= CPRS_ST_VLO;
            vlo_q <= 8'h00;
        end else if (ce) begin
            case (state_q)
                CPRS_ST_VLO: begin
                    vlo_q <= pmem_rdata;
                    state_q <= CPRS_ST_VHI;
                end
                CPRS_ST_VHI: begin
                    state_q <= CPRS_ST_RUN;
                end
                CPRS_ST_RUN: begin
                    state_q <= CPRS_ST_RUN;
                end
                default: begin
                    state_q <= CPRS_ST_VLO;
                end
            endcase
        end
    end

    // RL22 even address for low byte, odd for high byte
    always_comb begin
        pmem_rd = (state_q == CPRS_ST_VLO) || (state_q == CPRS_ST_VHI);
        if (state_q == CPRS_ST_VHI) begin
            pmem_addr = `CPRS_VEC_RESET_HI;
        end else begin
            pmem_addr = `CPRS_VEC_RESET_LO;
        end
    end

    assign fetch_ready = (state_q == CPRS_ST_RUN);

    // ----------------------------------------
    // Program counter
    // ----------------------------------------
    // Only steps or branches once the vector is in
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pc_q <= 16'h0000;
        end else if (ce) begin
            if (state_q == CPRS_ST_VHI) begin
                // RL2 vector load
                pc_q <= {pmem_rdata, vlo_q};
            end else if (state_q == CPRS_ST_RUN) begin
                case (pc_op)
                    // RL1 sequential advance
                    CPRS_PC_STEP: begin
                        pc_q <= pc_q + {14'h0000, instr_len_m1} + 16'h0001;
                    end
                    // RL3 branch target load
                    CPRS_PC_BRANCH: begin
                        pc_q <= branch_target;
                    end
                    default: begin
                        pc_q <= pc_q;
                    end
                endcase
            end
        end
    end

    assign program_counter = pc_q;

    // ----------------------------------------
    // Interrupt acceptance
    // ----------------------------------------
    // RL7 no maskable request while disabled; RL8 and RL13 mask and level gate
    assign irq_accept = fetch_ready && psw_q[`CPRS_PSW_IE] && irq_pending && !irq_masked
        && (psw_q[`CPRS_PSW_ISP] || !irq_low_prio);

    // ----------------------------------------
    // Status word
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // RL6 reset value
            psw_q <= `CPRS_PSW_RESET;
        end else if (ce && fetch_ready) begin
            case (psw_op)
                // RL9 disable
                CPRS_PSW_DI: begin
                    psw_q[`CPRS_PSW_IE] <= 1'b0;
                end
                // RL9 enable
                CPRS_PSW_EI: begin
                    psw_q[`CPRS_PSW_IE] <= 1'b1;
                end
                // RL11 bank select write
                CPRS_PSW_SEL: begin
                    psw_q[`CPRS_PSW_BANK_SELECT_HIGH] <= select_bank[1];
                    psw_q[`CPRS_PSW_BANK_SELECT_LOW] <= select_bank[0];
                end
                // RL5 restore from stack, or direct write of the status word
                CPRS_PSW_POP, CPRS_PSW_WR: begin
                    psw_q <= psw_wdata;
                end
                // RL9 acknowledge clears enable
                CPRS_PSW_ACK: begin
                    psw_q[`CPRS_PSW_IE] <= 1'b0;
                end
                default: begin
                    // RL10 zero flag
                    if (alu_flags.zero_upd) begin
                        psw_q[`CPRS_PSW_Z] <= alu_flags.zero;
                    end
                    // RL12 auxiliary carry
                    if (alu_flags.ac_upd) begin
                        psw_q[`CPRS_PSW_AC] <= alu_flags.ac;
                    end
                    // RL14 carry flag
                    if (alu_flags.cy_upd) begin
                        psw_q[`CPRS_PSW_CY] <= alu_flags.cy;
                    end
                end
            endcase
        end
    end

    // RL23 flag layout is fixed by the bit macros
    assign program_status_word = psw_q;

    // ----------------------------------------
    // Stack pointer
    // ----------------------------------------
    // Undefined after reset for software; zero is held here for determinism
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sp_q <= `CPRS_SP_RESET;
        end else if (ce && fetch_ready) begin
            case (sp_op)
                CPRS_SP_LOAD: begin
                    sp_q <= sp_wdata;
                end
                // RL16 predecrement on push, RL4 status pushes use this too
                CPRS_SP_PUSH: begin
                    sp_q <= sp_q - {14'h0000, sp_len};
                end
                // RL16 postincrement on pop
                CPRS_SP_POP: begin
                    sp_q <= sp_q + {14'h0000, sp_len};
                end
                default: begin
                    sp_q <= sp_q;
                end
            endcase
        end
    end

    assign stack_pointer = sp_q;

    // RL16 write address already decremented, read address is current value
    always_comb begin
        if (sp_op == CPRS_SP_PUSH) begin
            stack_addr = sp_q - {14'h0000, sp_len};
        end else begin
            stack_addr = sp_q;
        end
    end

    // ----------------------------------------
    // General registers
    // ----------------------------------------
    cprs_gpr_bank u_gpr (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .bank({psw_q[`CPRS_PSW_BANK_SELECT_HIGH], psw_q[`CPRS_PSW_BANK_SELECT_LOW]}),
        .wr(gpr_wr),
        .wide(gpr_wide),
        .idx(gpr_idx),
        .wdata(gpr_wdata),
        .mem_wr(mem_acc.wr && is_gpr(mem_acc.addr)),
        .mem_wide(mem_acc.wide),
        .mem_idx(mem_acc.addr[4:0]),
        .mem_wdata(mem_acc.wdata),
        .rdata(gpr_rdata),
        .mem_rdata(gpr_mem_rdata)
    );

    // ----------------------------------------
    // Data memory window decode
    // ----------------------------------------
    assign mem_hit_gpr = is_gpr(mem_acc.addr);
    assign mem_hit_sfr = is_sfr(mem_acc.addr);

    // RL20 SFR page select with access unit check; odd wide access is refused
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sfr_sel_q <= 1'b0;
            sfr_err_q <= 1'b0;
        end else if (ce) begin
            if (is_sfr(mem_acc.addr) && (mem_acc.rd || mem_acc.wr)) begin
                if (mem_acc.wide) begin
                    sfr_sel_q <= sfr_unit[2] && !mem_acc.addr[0];
                    sfr_err_q <= !sfr_unit[2] || mem_acc.addr[0];
                end else begin
                    sfr_sel_q <= sfr_unit[1];
                    sfr_err_q <= !sfr_unit[1];
                end
            end else begin
                sfr_sel_q <= 1'b0;
                sfr_err_q <= 1'b0;
            end
        end
    end

    assign sfr_sel = sfr_sel_q;
    assign sfr_err = sfr_err_q;

    // RL18 registered read data from the mapped register range
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_rdata_q <= 16'h0000;
        end else if (ce) begin
            if (mem_acc.rd && is_gpr(mem_acc.addr)) begin
                mem_rdata_q <= gpr_mem_rdata;
            end else begin
                mem_rdata_q <= 16'h0000;
            end
        end
    end

    assign mem_rdata = mem_rdata_q;
endmodule

// >>> dv/cprs_core_monitor.sv
// Concurrent checks on the processor register set ports
`timescale 1ns/1ns
`include "cprs_defs.svh"
module cprs_core_monitor
    import cprs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Requests
    input wire logic [7:0] pmem_rdata,
    input wire cprs_pc_op_t pc_op,
    input wire logic [1:0] instr_len_m1,
    input wire cprs_psw_op_t psw_op,
    input wire logic [1:0] select_bank,
    input wire logic [7:0] psw_wdata,
    input wire cprs_sp_op_t sp_op,
    input wire logic [1:0] sp_len,
    input wire logic irq_pending,
    input wire logic irq_masked,
    input wire logic irq_low_prio,
    input wire cprs_acc_t mem_acc,
    input wire logic [2:0] sfr_unit,
    // State and answers
    input wire logic [15:0] program_counter,
    input wire logic fetch_ready,
    input wire logic [7:0] program_status_word,
    input wire logic [15:0] stack_pointer,
    input wire logic [15:0] stack_addr,
    input wire logic irq_accept,
    input wire logic sfr_sel,
    input wire logic sfr_err
);
    // ----------
    // Properties
    // ----------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Ops count only once the vector is in and the clock is enabled
    wire run = fetch_ready & ce;
    wire [7:0] ps = program_status_word;
    wire sfr_acc = ce & (mem_acc.rd | mem_acc.wr) & (mem_acc.addr[15:8] == `CPRS_SFR_PAGE);
    chk_pc_step: assert property (
        run && pc_op == CPRS_PC_STEP |=> program_counter == $past(program_counter) + 16'($past(instr_len_m1)) + 16'h1
    ) else $error("pc step wrong");
    chk_vector_load: assert property (
        $rose(fetch_ready) |-> program_counter == {$past(pmem_rdata), $past(pmem_rdata, 2)}
    ) else $error("vector load wrong");
    chk_psw_reset: assert property (
        $rose(fetch_ready) |-> ps == `CPRS_PSW_RESET
    ) else $error("status reset wrong");
    chk_psw_restore: assert property (
        run && psw_op == CPRS_PSW_POP |=> ps == $past(psw_wdata)
    ) else $error("status restore wrong");
    chk_ie_refuse: assert property (
        !ps[`CPRS_PSW_IE] |-> !irq_accept
    ) else $error("irq taken while disabled");
    chk_irq_decide: assert property (
        run && ps[`CPRS_PSW_IE] |-> irq_accept == (irq_pending && !irq_masked && (ps[`CPRS_PSW_ISP] || !irq_low_prio))
    ) else $error("irq decision wrong");
    chk_ie_update: assert property (
        run && psw_op inside {CPRS_PSW_DI, CPRS_PSW_EI, CPRS_PSW_ACK} |=>
        ps[`CPRS_PSW_IE] == ($past(psw_op) == CPRS_PSW_EI)
    ) else $error("enable flag wrong");
    chk_bank_field: assert property (
        run && psw_op == CPRS_PSW_SEL |=> {ps[`CPRS_PSW_BANK_SELECT_HIGH], ps[`CPRS_PSW_BANK_SELECT_LOW]} == $past(select_bank)
    ) else $error("bank field wrong");
    chk_sp_push: assert property (
        run && sp_op == CPRS_SP_PUSH |-> stack_addr == stack_pointer - 16'(sp_len) ##1 stack_pointer == $past(stack_addr)
    ) else $error("push pointer wrong");
    chk_sp_pop: assert property (
        run && sp_op == CPRS_SP_POP |-> stack_addr == stack_pointer ##1
        stack_pointer == $past(stack_pointer) + 16'($past(sp_len))
    ) else $error("pop pointer wrong");
    chk_sfr_refuse: assert property (
        sfr_acc && mem_acc.wide && (mem_acc.addr[0] || !sfr_unit[2]) |=> sfr_err && !sfr_sel
    ) else $error("bad sfr access not refused");
    // Main scenarios seen
    cover property (run && irq_accept);
    cover property (run && sp_op == CPRS_SP_PUSH);
    cover property (sfr_err);
endmodule
bind cprs_core cprs_core_monitor u_cprs_core_monitor (
    .clk, .rst, .ce, .pmem_rdata, .pc_op, .instr_len_m1, .psw_op, .select_bank, .psw_wdata, .sp_op, .sp_len,
    .irq_pending, .irq_masked, .irq_low_prio, .mem_acc, .sfr_unit, .program_counter, .fetch_ready,
    .program_status_word, .stack_pointer, .stack_addr, .irq_accept, .sfr_sel, .sfr_err
);

// >>> dv/tb.sv
// Self-checking bench for the processor register set
`timescale 1ns/1ns
module tb
    import cprs_pkg::*;
;
    // -------
    // Signals
    // -------
    logic clk = 0;
    logic rst, ce, irq_pending, irq_masked, irq_low_prio, gpr_wr, gpr_wide;
    logic pmem_rd, fetch_ready, irq_accept, mem_hit_gpr, mem_hit_sfr, sfr_sel, sfr_err;
    logic [1:0] instr_len_m1, select_bank, sp_len;
    logic [2:0] gpr_idx, sfr_unit;
    logic [7:0] psw_wdata, program_status_word, vlo, vhi, ps;
    logic [7:0] gr [32];
    logic [15:0] branch_target, sp_wdata, gpr_wdata, pmem_addr, program_counter, stack_pointer;
    logic [15:0] stack_addr, gpr_rdata, mem_rdata, pc, sp;
    cprs_pc_op_t pc_op;
    cprs_psw_op_t psw_op;
    cprs_sp_op_t sp_op;
    cprs_flags_t alu_flags;
    cprs_acc_t mem_acc;
    int cyc = 0;
    int n_mismatch = 0;
    int samples_checked = 0;
    integer seed = 32'hc58d;
    int qk [$];
    int qd [$];
    logic [15:0] qv [$];
    string nm [10] = '{"pc", "psw", "sp", "stack_addr", "irq_accept", "gpr_rdata", "mem_rdata", "gpr_byte",
        "sfr", "hits"};
    // Program memory answers the vector fetch combinationally
    wire [7:0] pmem_rdata = pmem_addr[0] ? vhi : vlo;

    cprs_core u_cprs_core (
        .clk, .rst, .ce, .pmem_addr, .pmem_rd, .pmem_rdata, .pc_op, .instr_len_m1, .branch_target,
        .program_counter, .fetch_ready, .psw_op, .select_bank, .psw_wdata, .alu_flags, .program_status_word,
        .sp_op, .sp_len, .sp_wdata, .stack_pointer, .stack_addr, .irq_pending, .irq_masked, .irq_low_prio,
        .irq_accept, .gpr_wr, .gpr_wide, .gpr_idx, .gpr_wdata, .gpr_rdata, .mem_acc, .sfr_unit, .mem_rdata,
        .mem_hit_gpr, .mem_hit_sfr, .sfr_sel, .sfr_err
    );

    // -----------------
    // Clock and helpers
    // -----------------
    always #5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    function automatic logic [15:0] obs(int k);
        case (k)
            0: obs = program_counter;
            1: obs = {8'h00, program_status_word};
            2: obs = stack_pointer;
            3: obs = stack_addr;
            4: obs = {15'h0000, irq_accept};
            5: obs = gpr_rdata;
            6: obs = {8'h00, mem_rdata[7:0]};
            7: obs = {8'h00, gpr_rdata[7:0]};
            8: obs = {14'h0000, sfr_sel, sfr_err};
            default: obs = {13'h0000, pmem_rd, mem_hit_gpr, mem_hit_sfr};
        endcase
    endfunction

    task automatic chk(string n, logic [15:0] s, logic [15:0] e);
        samples_checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask

    // Expected result, due d cycles after the current drive; push in order of due cycle
    task automatic note(int k, int d, logic [15:0] v);
        qk.push_back(k);
        qd.push_back(cyc + d);
        qv.push_back(v);
    endtask

    // Drive one cycle of ops just after the edge, then hold until the next one
    task automatic st(cprs_pc_op_t p, cprs_psw_op_t s, cprs_sp_op_t k);
        pc_op = p;
        psw_op = s;
        sp_op = k;
        @(posedge clk);
        #1;
    endtask

    task automatic rs();
        rst = 1;
        mem_acc = '0;
        repeat (3) @(posedge clk);
        #1;
        rst = 0;
        note(9, 0, 16'h0004);
        repeat (2) @(posedge clk);
        #1;
        note(0, 0, {vhi, vlo});
        note(1, 0, 16'h0002);
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Results are compared mid-cycle, where every output has settled
    always @(negedge clk) begin
        while (qd.size() > 0 && qd[0] <= cyc) begin
            chk(nm[qk[0]], obs(qk[0]), qv[0]); // Tag sits on each note
            void'(qk.pop_front());
            void'(qd.pop_front());
            void'(qv.pop_front());
        end
    end

    // Watchdog: the whole sequence needs well under 2000 cycles
    initial begin
        #20000;
        n_mismatch++;
        summarize();
    end

    // ---------
    // Sequence
    // ---------
    initial begin
        pc_op = CPRS_PC_HOLD;
        psw_op = CPRS_PSW_NOP;
        sp_op = CPRS_SP_NOP;
        ce = 1;
        {instr_len_m1, branch_target, select_bank, psw_wdata, alu_flags, sp_len, sp_wdata} = '0;
        {irq_pending, irq_masked, irq_low_prio, gpr_wr, gpr_wide, gpr_idx, gpr_wdata, mem_acc, sfr_unit} = '0;
        vlo = $random(seed);
        vhi = $random(seed);
        rs();
        pc = {vhi, vlo};
        for (int i = 0; i < 4; i++) begin
            instr_len_m1 = i[1:0];
            pc = pc + 16'(i) + 16'h0001;
            note(0, 1, pc);
            st(CPRS_PC_STEP, CPRS_PSW_NOP, CPRS_SP_NOP);
        end
        branch_target = $random(seed);
        note(0, 1, branch_target);
        st(CPRS_PC_BRANCH, CPRS_PSW_EI, CPRS_SP_NOP);
        // A disabled clock must freeze the counter
        ce = 0;
        note(0, 1, branch_target);
        st(CPRS_PC_STEP, CPRS_PSW_NOP, CPRS_SP_NOP);
        ce = 1;
        ps = 8'h82;
        for (int b = 0; b < 4; b++) begin
            select_bank = b[1:0];
            ps[5] = b[1];
            ps[3] = b[0];
            note(1, 1, {8'h00, ps});
            st(CPRS_PC_HOLD, CPRS_PSW_SEL, CPRS_SP_NOP);
        end
        for (int i = 0; i < 8; i++) begin
            alu_flags = $random(seed);
            ps[6] = alu_flags.zero_upd ? alu_flags.zero : ps[6];
            ps[4] = alu_flags.ac_upd ? alu_flags.ac : ps[4];
            ps[0] = alu_flags.cy_upd ? alu_flags.cy : ps[0];
            note(1, 1, {8'h00, ps});
            st(CPRS_PC_HOLD, CPRS_PSW_NOP, CPRS_SP_NOP);
        end
        alu_flags = '0;
        note(1, 1, {8'h00, ps & 8'h7f});
        st(CPRS_PC_HOLD, CPRS_PSW_DI, CPRS_SP_NOP);
        // Every mix of enable, priority, pending, mask and level
        for (int i = 0; i < 32; i++) begin
            psw_wdata = {i[4], 5'h00, i[3], 1'b0};
            st(CPRS_PC_HOLD, CPRS_PSW_WR, CPRS_SP_NOP);
            {irq_pending, irq_masked, irq_low_prio} = i[2:0];
            note(4, 0, {15'h0000, i[4] & i[2] & ~i[1] & (i[3] | ~i[0])});
            st(CPRS_PC_HOLD, CPRS_PSW_NOP, CPRS_SP_NOP);
        end
        sp_wdata = 16'hfee0;
        sp = 16'hfee0;
        note(2, 1, sp);
        st(CPRS_PC_HOLD, CPRS_PSW_NOP, CPRS_SP_LOAD);
        for (int i = 1; i < 4; i++) begin
            sp_len = i[1:0];
            sp = sp - 16'(i);
            note(3, 0, sp);
            note(2, 1, sp);
            st(CPRS_PC_HOLD, CPRS_PSW_NOP, CPRS_SP_PUSH);
        end
        note(1, 1, 16'h0002);
        st(CPRS_PC_HOLD, CPRS_PSW_ACK, CPRS_SP_NOP);
        for (int i = 3; i > 0; i--) begin
            sp_len = i[1:0];
            psw_wdata = $random(seed);
            note(3, 0, sp);
            sp = sp + 16'(i);
            note(2, 1, sp);
            note(1, 1, {8'h00, psw_wdata});
            st(CPRS_PC_HOLD, CPRS_PSW_POP, CPRS_SP_POP);
        end
        // Fill every general register through the data window
        mem_acc.wr = 1;
        for (int n = 0; n < 32; n++) begin
            mem_acc.addr = 16'hfee0 + 16'(n);
            mem_acc.wdata = $random(seed);
            gr[n] = mem_acc.wdata[7:0];
            st(CPRS_PC_HOLD, CPRS_PSW_NOP, CPRS_SP_NOP);
        end
        mem_acc.wr = 0;
        mem_acc.rd = 1;
        for (int n = 0; n < 32; n++) begin
            select_bank = n[4:3];
            if (n[2:0] == 3'h0)
                st(CPRS_PC_HOLD, CPRS_PSW_SEL, CPRS_SP_NOP);
            mem_acc.addr = 16'hfee0 + 16'(n);
            gpr_idx = n[2:0];
            gpr_wide = n[2];
            if (n[2])
                note(5, 0, {gr[n | 1], gr[n & 30]});
            else
                note(7, 0, {8'h00, gr[n]});
            note(9, 0, 16'h0002);
            note(6, 1, {8'h00, gr[n]});
            st(CPRS_PC_HOLD, CPRS_PSW_NOP, CPRS_SP_NOP);
        end
        gpr_wr = 1;
        gpr_idx = 3'h6;
        gpr_wdata = $random(seed);
        st(CPRS_PC_HOLD, CPRS_PSW_NOP, CPRS_SP_NOP);
        gpr_wr = 0;
        note(5, 0, gpr_wdata);
        st(CPRS_PC_HOLD, CPRS_PSW_NOP, CPRS_SP_NOP);
        // Odd wide, unsupported wide and legal accesses in the top page
        // pairs legal only at even addresses with sfr_unit[2] set; byte accesses legal with sfr_unit[1] set, as it always is here
        for (int i = 0; i < 8; i++) begin
            mem_acc.addr = 16'hff00 | 16'($random(seed) & 32'hfe) | 16'(i[0]);
            mem_acc.wide = i[1];
            sfr_unit = {i[2], 2'b11};
            note(9, 0, 16'h0001);
            note(8, 1, {14'h0000, ~(i[1] & (i[0] | ~i[2])), i[1] & (i[0] | ~i[2])});
            st(CPRS_PC_HOLD, CPRS_PSW_NOP, CPRS_SP_NOP);
        end
        // Let the last refusal flags be compared before reset wipes them
        st(CPRS_PC_HOLD, CPRS_PSW_NOP, CPRS_SP_NOP);
        rs();
        repeat (3) @(posedge clk);
        summarize();
    end
endmodule
